// [rtl/bsp_pkg.sv]
// Constants for the backup scratch and pad pull register bank
package bsp_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_SCRATCH = 4;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_SCRATCH_2 = 6'h18;
    localparam logic [5:0] IDX_SCRATCH_3 = 6'h19;
    localparam logic [5:0] IDX_SCRATCH_4 = 6'h1A;
    localparam logic [5:0] IDX_SCRATCH_5 = 6'h1B;
    localparam logic [5:0] IDX_PAD_PULL = 6'h1C;
    // Byte addresses
    localparam logic [7:0] ADDR_SCRATCH_2 = 8'h60;
    localparam logic [7:0] ADDR_PAD_PULL = 8'h70;
    // Reset values and pad pull write mask
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [7:0] PAD_PULL_RESET = 8'h1F;
    localparam logic [7:0] PAD_PULL_WMASK = 8'h7F;
    // Pad pull control fields
    localparam int BIT_CTL_BUS = 6;
    localparam int BIT_SCALING_BUS = 5;
    localparam int BIT_POWER_ON = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_HOLD = 2;
    localparam int BIT_COLD_RESET = 1;
    localparam int BIT_SECOND_RESET = 0;
    localparam int BIT_RESERVED = 7;
    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/bsp_regs.sv]
// Backup scratch bytes and pad pull control register behind an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module bsp_regs
    import bsp_pkg::*;
(
    // Clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic gen_resetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pad pull enables
    output logic ctl_bus_pullup_en,
    output logic scaling_bus_pullup_en,
    output logic power_on_pad_pullup_en,
    output logic sleep_pad_pulldown_en,
    output logic hold_pad_pulldown_en,
    output logic cold_reset_pad_pulldown_en,
    output logic second_reset_out_pulldown_en
);

    // Held write address and data, taken in either order
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_hold;
    logic [REG_W-1:0] w_data_q;
    logic w_strb_q;
    logic [REG_W-1:0] scratch_byte [NUM_SCRATCH];
    logic [REG_W-1:0] pad_pull_control;

    // Channel acceptance; each side takes nothing new while its own response waits
    assign awready = !aw_hold && !bvalid;
    assign wready = !w_hold && !bvalid;
    assign arready = !rvalid;

    // Current write payload, from the hold register or straight off the bus
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire have_aw = aw_hold || aw_take;
    wire have_w = w_hold || w_take;
    wire do_write = have_aw && have_w;
    wire [ADDR_W-1:0] wr_addr = aw_hold ? aw_addr_q : awaddr;
    wire [REG_W-1:0] wr_data = w_hold ? w_data_q : wdata[REG_W-1:0];
    wire wr_lane0 = w_hold ? w_strb_q : wstrb[0];
    wire [5:0] wr_idx = wr_addr[7:2];
    wire [5:0] rd_idx = araddr[7:2];

    // Write decode
    wire wr_scratch_hit = (wr_idx >= IDX_SCRATCH_2) && (wr_idx <= IDX_SCRATCH_5);
    wire wr_pad_hit = (wr_idx == IDX_PAD_PULL);
    wire wr_hit = wr_scratch_hit || wr_pad_hit;
    wire [1:0] wr_slot = 2'(wr_idx - IDX_SCRATCH_2);

    // Read decode and data selection
    wire rd_scratch_hit = (rd_idx >= IDX_SCRATCH_2) && (rd_idx <= IDX_SCRATCH_5);
    wire rd_pad_hit = (rd_idx == IDX_PAD_PULL);
    wire [1:0] rd_slot = 2'(rd_idx - IDX_SCRATCH_2);
    wire [REG_W-1:0] rd_byte = rd_scratch_hit ? scratch_byte[rd_slot] :
                               rd_pad_hit ? pad_pull_control : SCRATCH_RESET;
    wire rd_hit = rd_scratch_hit || rd_pad_hit;

    // Write address and data holding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            aw_addr_q <= 8'h00;
            w_hold <= 1'b0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
        end
        else
        begin
            if (aw_take && !do_write)
            begin
                aw_hold <= 1'b1;
                aw_addr_q <= awaddr;
            end
            else if (do_write)
            begin
                aw_hold <= 1'b0;
            end
            if (w_take && !do_write)
            begin
                w_hold <= 1'b1;
                w_data_q <= wdata[REG_W-1:0];
                w_strb_q <= wstrb[0];
            end
            else if (do_write)
            begin
                w_hold <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // Scratch bytes: full reset domain, kept otherwise
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SCRATCH; gi++)
        begin : g_scratch
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    scratch_byte[gi] <= SCRATCH_RESET;
                else if (do_write && wr_lane0 && wr_scratch_hit && wr_slot == 2'(gi))
                    scratch_byte[gi] <= wr_data;
            end
        end
    endgenerate

    // Pad pull control: general reset only, reserved bit forced low
    always_ff @(posedge aclk)
    begin
        if (!gen_resetn)
            pad_pull_control <= PAD_PULL_RESET;
        else if (aresetn && do_write && wr_lane0 && wr_pad_hit)
            pad_pull_control <= wr_data & PAD_PULL_WMASK;
    end

    // Pad pull enables straight from the register
    assign ctl_bus_pullup_en = pad_pull_control[BIT_CTL_BUS];
    assign scaling_bus_pullup_en = pad_pull_control[BIT_SCALING_BUS];
    assign power_on_pad_pullup_en = pad_pull_control[BIT_POWER_ON];
    assign sleep_pad_pulldown_en = pad_pull_control[BIT_SLEEP];
    assign hold_pad_pulldown_en = pad_pull_control[BIT_HOLD];
    assign cold_reset_pad_pulldown_en = pad_pull_control[BIT_COLD_RESET];
    assign second_reset_out_pulldown_en = pad_pull_control[BIT_SECOND_RESET];

    // Read data channel, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // Protection bits are accepted and not used
    wire unused_prot = ^{awprot, arprot, wdata[DATA_W-1:REG_W], wstrb[3:1]};

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_scratch_store;
        logic [7:0] d;
        (do_write && wr_lane0 && wr_idx == IDX_SCRATCH_2, d = wr_data)
            |=> scratch_byte[0] == d;
    endproperty
    a_scratch_store: assert property (p_scratch_store) else $error("scratch write lost");

    property p_scratch_clear;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> scratch_byte[0] == SCRATCH_RESET && scratch_byte[1] == SCRATCH_RESET &&
            scratch_byte[2] == SCRATCH_RESET && scratch_byte[3] == SCRATCH_RESET;
    endproperty
    a_scratch_clear: assert property (p_scratch_clear) else $error("scratch not cleared");

    property p_scratch_read;
        logic [7:0] d;
        (arvalid && arready && araddr == ADDR_SCRATCH_2, d = scratch_byte[0])
            |=> rvalid && rdata == {24'h000000, d} && rresp == RESP_OKAY;
    endproperty
    a_scratch_read: assert property (p_scratch_read) else $error("scratch read wrong");

    property p_pad_keep;
        @(posedge aclk) disable iff (1'b0)
        !aresetn && gen_resetn |=> $stable(pad_pull_control);
    endproperty
    a_pad_keep: assert property (p_pad_keep) else $error("pad reg hit by full reset");

    property p_ctl_reset;
        !gen_resetn |=> !ctl_bus_pullup_en;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("ctl pullup reset");

    property p_scaling_reset;
        !gen_resetn |=> !scaling_bus_pullup_en;
    endproperty
    a_scaling_reset: assert property (p_scaling_reset) else $error("scaling reset");

    property p_power_on_write;
        logic v;
        (do_write && wr_lane0 && wr_pad_hit && gen_resetn, v = wr_data[BIT_POWER_ON])
            |=> power_on_pad_pullup_en == v;
    endproperty
    a_power_on_write: assert property (p_power_on_write) else $error("power-on bit");

    property p_low_reset;
        !gen_resetn |=> sleep_pad_pulldown_en && hold_pad_pulldown_en;
    endproperty
    a_low_reset: assert property (p_low_reset) else $error("sleep/hold reset");

    property p_reset_pads;
        !gen_resetn |=> cold_reset_pad_pulldown_en && second_reset_out_pulldown_en;
    endproperty
    a_reset_pads: assert property (p_reset_pads) else $error("reset pad pulls");

    property p_reserved;
        (arvalid && arready && araddr == ADDR_PAD_PULL) |=> !rdata[BIT_RESERVED];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_bresp_wait;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bresp_wait: assert property (p_bresp_wait) else $error("bvalid dropped");

    // Scratch bytes hold still unless a write lands in the scratch range
    property p_scratch_hold;
        !(do_write && wr_lane0 && wr_scratch_hit) |=>
            $stable(scratch_byte[0]) && $stable(scratch_byte[1]) &&
            $stable(scratch_byte[2]) && $stable(scratch_byte[3]);
    endproperty
    a_scratch_hold: assert property (p_scratch_hold) else $error("scratch byte changed");

    // Any scratch slot reads back its own byte one cycle after the address
    property p_slot_read;
        logic [7:0] d;
        (arvalid && arready && rd_scratch_hit, d = scratch_byte[rd_slot])
            |=> rvalid && rdata == {24'h000000, d} && rresp == RESP_OKAY;
    endproperty
    a_slot_read: assert property (p_slot_read) else $error("scratch slot read");

    // General reset turns the power-on pullup back on
    property p_power_on_reset;
        !gen_resetn |=> power_on_pad_pullup_en;
    endproperty
    a_power_on_reset: assert property (p_power_on_reset) else $error("power-on reset");

    // A pad register write drives every enable output from its own bit
    property p_pad_write;
        logic [6:0] v;
        (do_write && wr_lane0 && wr_pad_hit && gen_resetn,
            v = wr_data[BIT_CTL_BUS:BIT_SECOND_RESET])
            |=> {ctl_bus_pullup_en, scaling_bus_pullup_en, power_on_pad_pullup_en,
                sleep_pad_pulldown_en, hold_pad_pulldown_en, cold_reset_pad_pulldown_en,
                second_reset_out_pulldown_en} == v;
    endproperty
    a_pad_write: assert property (p_pad_write) else $error("pad write");

    // The reserved bit stays low whatever a pad write carries
    property p_reserved_write;
        do_write && wr_lane0 && wr_pad_hit && gen_resetn |=> !pad_pull_control[BIT_RESERVED];
    endproperty
    a_reserved_write: assert property (p_reserved_write) else $error("reserved stored");

    // Reading the pad register returns its enables with the reserved bit low
    property p_pad_read;
        logic [7:0] v;
        (arvalid && arready && rd_pad_hit, v = pad_pull_control)
            |=> rvalid && rdata == {24'h000000, v} && rresp == RESP_OKAY;
    endproperty
    a_pad_read: assert property (p_pad_read) else $error("pad read");

    // An unmapped write answers with an error and leaves the pad register alone
    property p_bad_write;
        do_write && !wr_hit && gen_resetn |=>
            bvalid && bresp == RESP_SLVERR && $stable(pad_pull_control);
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("unmapped write");

    // An unmapped read answers with an error and zero data
    property p_bad_read;
        arvalid && arready && !rd_hit |=>
            rvalid && rresp == RESP_SLVERR && rdata == 32'h00000000;
    endproperty
    a_bad_read: assert property (p_bad_read) else $error("unmapped read");

    // A completed write answers next cycle and blocks new write requests
    property p_write_answer;
        do_write |=> bvalid && !awready && !wready;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");

    // A taken read address answers next cycle and blocks the next one
    property p_read_answer;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    c_write_split: cover property (aw_hold ##[1:4] do_write);
    c_write_data_first: cover property (w_hold ##[1:4] do_write);
    c_pad_read: cover property (arvalid && arready && araddr == ADDR_PAD_PULL);
    c_bad_addr: cover property (bvalid && bresp == RESP_SLVERR);
    c_gen_reset_only: cover property (!gen_resetn && aresetn);

endmodule
`default_nettype wire

// [verif/tb_bsp_regs.sv]
// Self-checking bench for the backup scratch and pad pull register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_bsp_regs;
    import bsp_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0] r;
        logic [6:0] p;
    } bsp_row_t;
    logic aclk, aresetn, gen_resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    wire [6:0] pulls;
    int n_fail, tests_run;
    bsp_row_t rows [9];
    bsp_regs u_dut (.aclk(aclk), .aresetn(aresetn), .gen_resetn(gen_resetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .ctl_bus_pullup_en(pulls[6]),
        .scaling_bus_pullup_en(pulls[5]), .power_on_pad_pullup_en(pulls[4]),
        .sleep_pad_pulldown_en(pulls[3]), .hold_pad_pulldown_en(pulls[2]),
        .cold_reset_pad_pulldown_en(pulls[1]), .second_reset_out_pulldown_en(pulls[0]));
    // Clock at 25 MHz
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Write with address and data offered together; handshakes are read on the falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
                      output logic [1:0] resp);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dv;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask
    // Read one register; rready stays up until the data is taken
    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] resp);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            dv = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask
    // Pulse either reset for two cycles
    task automatic pulse(input logic full, input logic gen);
        @(posedge aclk);
        aresetn <= ~full;
        gen_resetn <= ~gen;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        gen_resetn <= 1'b1;
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog well beyond the expected hundred or so cycles
    initial
    begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        aresetn = 1'b0;
        gen_resetn = 1'b0;
        n_fail = 0;
        tests_run = 0;
        rows = '{
            '{8'h60, 32'hA5, 32'hA5, RESP_OKAY, 7'h1F},
            '{8'h64, 32'h5A, 32'h5A, RESP_OKAY, 7'h1F},
            '{8'h68, 32'hFFFFFFFF, 32'hFF, RESP_OKAY, 7'h1F},
            '{8'h6C, 32'h01, 32'h01, RESP_OKAY, 7'h1F},
            '{8'h70, 32'hFF, 32'h7F, RESP_OKAY, 7'h7F},
            '{8'h70, 32'h00, 32'h00, RESP_OKAY, 7'h00},
            '{8'h72, 32'h40, 32'h40, RESP_OKAY, 7'h40},
            '{8'h74, 32'h12, 32'h00, RESP_SLVERR, 7'h40},
            '{8'h5C, 32'h34, 32'h00, RESP_SLVERR, 7'h40}};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        gen_resetn <= 1'b1;
        `CHK(pulls, 7'h1F)
        for (int i = 0; i < 4; i++)
        begin
            rd(ADDR_SCRATCH_2 + 8'(4 * i), d, r);
            `CHK(d, 32'h0)
        end
        rd(ADDR_PAD_PULL, d, r);
        `CHK(d, 32'h1F)
        // Table of write, read back and pad outputs
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d, 4'hF, r);
            `CHK(r, rows[i].r)
            rd(rows[i].a, d, r);
            `CHK({r, d}, {rows[i].r, rows[i].q})
            `CHK(pulls, rows[i].p)
        end
        // Byte lane zero disabled leaves the scratch byte untouched
        wr(8'h60, 32'h3C, 4'hE, r);
        rd(8'h60, d, r);
        `CHK(d, 32'hA5)
        // General reset restores the pads and keeps the scratch bytes
        pulse(1'b0, 1'b1);
        `CHK(pulls, 7'h1F)
        rd(8'h6C, d, r);
        `CHK(d, 32'h01)
        // Full reset clears scratch bytes and leaves the pads alone
        wr(8'h70, 32'h2A, 4'h1, r);
        pulse(1'b1, 1'b0);
        `CHK(pulls, 7'h2A)
        rd(8'h64, d, r);
        `CHK(d, 32'h0)
        rd(8'h70, d, r);
        `CHK(d, 32'h2A)
        end_sim();
    end
endmodule
`default_nettype wire
